// *** rtl/mrc_defines.vh ***
`ifndef MRC_DEFINES_VH
`define MRC_DEFINES_VH
// ==========================================================================
// Register map: printed offsets are not multiples of four, so they are
// indices and the byte address is four times the index.
`define MRC_IDX_MODE       4'h3
`define MRC_IDX_LEGACY     4'h4
`define MRC_IDX_REFCLK     4'h5
`define MRC_IDX_STRAPIN    4'h6
// ==========================================================================
// Field positions.
`define MRC_MODE_LSB       0
`define MRC_MODE_MSB       2
`define MRC_DONE_BIT       3
`define MRC_OVR_BIT        4
`define MRC_BLOCK_BIT      0
`define MRC_RAW12_BIT      1
`define MRC_RAW10_BIT      2
`define MRC_OSC_BIT        3
`define MRC_DIV_LSB        4
`define MRC_DIV_MSB        6
// ==========================================================================
// Reset values.
`define MRC_MODE_RST       8'h00
`define MRC_LEGACY_RST     8'h00
`define MRC_REFCLK_RST     8'h03
// ==========================================================================
// Mode encodings.
`define MRC_MODE_SYNC      3'h0
`define MRC_MODE_RSVD      3'h1
`define MRC_MODE_NS_EXT    3'h2
`define MRC_MODE_NS_AON    3'h3
`define MRC_MODE_PVID      3'h5
// ==========================================================================
// Timing: settle time of the strap before the mode counts as latched.
`define MRC_SETTLE_NS      100
`define MRC_CLK_NS         10
`define MRC_SETTLE_CYC     ((`MRC_SETTLE_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS)
`endif

// *** rtl/mrc_refclk_div.v ***
`timescale 1ns/100ps
// ==========================================================================
// Reference clock divider
// ==========================================================================
// Produces a one-cycle tick every 1, 2, 4 or 8 edges of the sampled
// external clock; reserved codes behave as divide by one.
module mrc_refclk_div (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ext_clk_rise,
    input  wire [2:0] div_sel,
    output reg        ref_tick
);
    reg [2:0] count;
    reg [2:0] limit;

    // Terminal count for the chosen ratio.
    always @* begin
        case (div_sel)
            3'h1:    limit = 3'h1;
            3'h2:    limit = 3'h3;
            3'h3:    limit = 3'h7;
            default: limit = 3'h0;
        endcase
    end

    // Count input edges and emit a tick at the terminal count.
    always @(posedge aclk) begin
        if (!aresetn) begin
            count    <= 3'h0;
            ref_tick <= 1'b0;
        end else begin
            ref_tick <= 1'b0;
            if (ext_clk_rise) begin
                if (count >= limit) begin
                    count    <= 3'h0;
                    ref_tick <= 1'b1;
                end else begin
                    count <= count + 3'h1;
                end
            end
        end
    end
endmodule

// *** rtl/mrc_config.v ***
// Operation
// - Override bit 4 clear: mode follows strap, mode field writes ignored.
// - Override bit 4 set: software writes replace the strapped mode.
// - Mode field always reads the mode currently in effect.
// - Strap mode is captured on the power-enable rising edge.
// - Bit 3 reads one only after mode settled and latched; zero at reset.
// - Modes: 000 sync, 010 ext clock, 011 always-on clock, 101 video.
// - RAW10 bit 2 set by control channel on lock unless blocked.
// - RAW12 bit 1 set by control channel on lock unless blocked.
// - Bit 0 set stops autoload; software writing format bits sets it (here a write stores bit 0 only as written).
// - Divider bits 6:4 divide input clock by 1, 2, 4 or 8.
// - Bit 3 selects oscillator range: 0 for 2 Gbps, 1 for 4 Gbps.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mrc_defines.vh"
module mrc_config #(
    parameter SETTLE_CYCLES = `MRC_SETTLE_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        power_enable_pin,
    input  wire [2:0]  mode_strap,
    input  wire        external_input_clock,
    input  wire        external_clock_present,
    input  wire        rx_lock,
    input  wire        remote_raw10,
    input  wire        remote_raw12,
    output reg  [2:0]  operating_mode,
    output reg         mode_settled,
    output reg         raw10_legacy_select,
    output reg         raw12_legacy_select,
    output reg         internal_ref_tick,
    output reg         oscillator_range_select,
    output reg         use_internal_oscillator
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_DONE   = 3'b100;

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    reg [2:0] pen_sync;
    reg [1:0] clk_sync;
    reg [1:0] lock_sync;
    reg [1:0] pres_sync;
    reg [2:0] strap_s1;
    reg [2:0] strap_s2;
    reg       clk_prev;
    reg       lock_prev;

    // Two stages before any logic; the third power-enable stage feeds edges.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pen_sync  <= 3'h0;
            clk_sync  <= 2'h0;
            lock_sync <= 2'h0;
            pres_sync <= 2'h0;
            strap_s1  <= 3'h0;
            strap_s2  <= 3'h0;
            clk_prev  <= 1'b0;
            lock_prev <= 1'b0;
        end else begin
            pen_sync  <= {pen_sync[1:0], power_enable_pin};
            clk_sync  <= {clk_sync[0], external_input_clock};
            lock_sync <= {lock_sync[0], rx_lock};
            pres_sync <= {pres_sync[0], external_clock_present};
            strap_s1  <= mode_strap;
            strap_s2  <= strap_s1;
            clk_prev  <= clk_sync[1];
            lock_prev <= lock_sync[1];
        end
    end

    wire pen_rise  = pen_sync[1] & ~pen_sync[2];
    wire clk_rise  = clk_sync[1] & ~clk_prev;
    wire lock_rise = lock_sync[1] & ~lock_prev;

    // ======================================================================
    // Register state
    // ======================================================================
    reg        strap_override_enable;
    reg        mode_rsvd7;
    reg        mode_rsvd5;
    reg [2:0]  strap_mode;
    reg [2:0]  sw_mode;
    reg [7:0]  legacy_reg;
    reg [7:0]  refclk_reg;
    reg [2:0]  settle_state;
    reg [15:0] settle_count;
    reg        mode_done;

    // Address decode, shared by the read and write paths.
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = addr[5:2];
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr[1:0] == 2'h0) && (addr[7:6] == 2'h0) &&
                     (addr[5:2] >= `MRC_IDX_MODE) &&
                     (addr[5:2] <= `MRC_IDX_STRAPIN);
        end
    endfunction

    // ======================================================================
    // AXI4-Lite write channel
    // ======================================================================
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write = aw_held & w_held & ~s_axi_bvalid;
    wire       wr_lane0 = do_write & w_strb[0];
    wire [3:0] wr_idx   = reg_index(aw_addr);

    // Address and data are taken in either order; response follows both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr) ? 2'h0 : 2'h3;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Mode register, strap capture and settle sequencer
    // ======================================================================
    // Strap is latched on the power-enable rise and re-latched, restarting the count,
    // on every change until it is stable for the settle time, so a bouncing strap is never reported as final.
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_override_enable <= 1'b0;
            mode_rsvd7            <= 1'b0;
            mode_rsvd5            <= 1'b0;
            strap_mode            <= `MRC_MODE_SYNC;
            sw_mode               <= `MRC_MODE_SYNC;
            settle_state          <= ST_IDLE;
            settle_count          <= 16'h0000;
            mode_done             <= 1'b0;
        end else begin
            if (wr_lane0 && wr_idx == `MRC_IDX_MODE) begin
                strap_override_enable <= w_data[`MRC_OVR_BIT];
                mode_rsvd7            <= w_data[7];
                mode_rsvd5            <= w_data[5];
                if (strap_override_enable | w_data[`MRC_OVR_BIT])
                    sw_mode <= w_data[`MRC_MODE_MSB:`MRC_MODE_LSB];
                else
                    sw_mode <= strap_mode;
            end
            if (pen_rise) begin
                strap_mode   <= strap_s2;
                settle_state <= ST_SETTLE;
                settle_count <= 16'h0000;
                mode_done    <= 1'b0;
            end else begin
                case (settle_state)
                    ST_IDLE: begin
                        mode_done <= 1'b0;
                    end
                    ST_SETTLE: begin
                        if (strap_s2 != strap_mode) begin
                            strap_mode   <= strap_s2;
                            settle_count <= 16'h0000;
                        end else if (settle_count >=
                                     SETTLE_CYCLES[15:0] - 16'h1) begin
                            settle_state <= ST_DONE;
                            mode_done    <= 1'b1;
                        end else begin
                            settle_count <= settle_count + 16'h1;
                        end
                    end
                    ST_DONE: begin
                        mode_done <= 1'b1;
                    end
                    default: begin
                        settle_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Mode in effect: the strap unless software has taken over.
    wire [2:0] active_mode = strap_override_enable ? sw_mode : strap_mode;

    // ======================================================================
    // Legacy format and reference clock registers
    // ======================================================================
    // A software write and a lock autoload in one cycle: software wins,
    // because it carries the newer intent.
    always @(posedge aclk) begin
        if (!aresetn) begin
            legacy_reg <= `MRC_LEGACY_RST;
            refclk_reg <= `MRC_REFCLK_RST;
        end else begin
            if (wr_lane0 && wr_idx == `MRC_IDX_LEGACY) begin
                legacy_reg <= w_data[7:0];
            end else if (lock_rise && !legacy_reg[`MRC_BLOCK_BIT]) begin
                legacy_reg[`MRC_RAW10_BIT] <= remote_raw10;
                legacy_reg[`MRC_RAW12_BIT] <= remote_raw12;
            end
            if (wr_lane0 && wr_idx == `MRC_IDX_REFCLK)
                refclk_reg <= w_data[7:0];
        end
    end

    // ======================================================================
    // Clock divider and registered outputs
    // ======================================================================
    wire div_tick;

    mrc_refclk_div u_div (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ext_clk_rise (clk_rise),
        .div_sel      (refclk_reg[`MRC_DIV_MSB:`MRC_DIV_LSB]),
        .ref_tick     (div_tick)
    );

    // Outputs come from flip-flops so downstream sees clean levels.
    always @(posedge aclk) begin
        if (!aresetn) begin
            operating_mode          <= `MRC_MODE_SYNC;
            mode_settled            <= 1'b0;
            raw10_legacy_select     <= 1'b0;
            raw12_legacy_select     <= 1'b0;
            internal_ref_tick       <= 1'b0;
            oscillator_range_select <= 1'b0;
            use_internal_oscillator <= 1'b0;
        end else begin
            operating_mode          <= active_mode;
            mode_settled            <= mode_done;
            raw10_legacy_select     <= legacy_reg[`MRC_RAW10_BIT];
            raw12_legacy_select     <= legacy_reg[`MRC_RAW12_BIT];
            internal_ref_tick       <= div_tick;
            oscillator_range_select <= refclk_reg[`MRC_OSC_BIT];
            use_internal_oscillator <= (active_mode == `MRC_MODE_NS_AON) |
                                       ~pres_sync[1];
        end
    end

    // ======================================================================
    // AXI4-Lite read channel
    // ======================================================================
    reg [7:0] rd_byte;

    // Read data mux; bit 6 of the mode register is a reserved read-only zero.
    always @* begin
        case (reg_index(s_axi_araddr))
            `MRC_IDX_MODE:    rd_byte = {mode_rsvd7, 1'b0, mode_rsvd5,
                                         strap_override_enable, mode_done,
                                         active_mode};
            `MRC_IDX_LEGACY:  rd_byte = legacy_reg;
            `MRC_IDX_REFCLK:  rd_byte = refclk_reg;
            `MRC_IDX_STRAPIN: rd_byte = {5'h00, strap_mode};
            default:          rd_byte = 8'h00;
        endcase
    end

    // One read at a time: arready pulses, data follows the next edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (mapped(s_axi_araddr)) begin
                    s_axi_rdata <= {24'h00_0000, rd_byte};
                    s_axi_rresp <= 2'h0;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h3;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** tb/mrc_config_sva.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Port checker for the mode and reference clock configuration block
// ==========================================================================
module mrc_config_sva #(
    parameter SETTLE_CYCLES = 10
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic       power_enable_pin,
    input wire logic       rx_lock,
    input wire logic [2:0] operating_mode,
    input wire logic       mode_settled,
    input wire logic       raw10_legacy_select,
    input wire logic       internal_ref_tick,
    input wire logic       use_internal_oscillator
);
    // One clock domain, so one clocking and one disable for all.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("bvalid dropped before bready");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read answer changed before rready");
    property p_read_latency;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("rvalid late after address taken");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response missing");
    property p_settled_reset;
        $rose(aresetn) |-> !mode_settled;
    endproperty
    a_settled_reset: assert property (p_settled_reset)
        else $error("settled flag set out of reset");
    // Sync stages and the settle count keep the flag at least four cycles late.
    property p_settled_after_pin;
        $rose(mode_settled) |-> $past(power_enable_pin, 4);
    endproperty
    a_settled_after_pin: assert property (p_settled_after_pin)
        else $error("settled flag rose without power enable");
    property p_mode_change;
        $changed(operating_mode) && mode_settled |-> $past(s_axi_bvalid);
    endproperty
    a_mode_change: assert property (p_mode_change)
        else $error("mode changed without write or strap latch");
    property p_raw10_cause;
        $changed(raw10_legacy_select) |-> rx_lock || $past(s_axi_bvalid);
    endproperty
    a_raw10_cause: assert property (p_raw10_cause)
        else $error("legacy format bit changed without cause");
    property p_tick_spacing;
        internal_ref_tick |=> !internal_ref_tick ##1 !internal_ref_tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("reference ticks too close");
    property p_internal_osc;
        (operating_mode == 3'h3) [*4] |-> use_internal_oscillator;
    endproperty
    a_internal_osc: assert property (p_internal_osc)
        else $error("internal oscillator not used in mode 011");
    c_settled: cover property ($rose(mode_settled));
    c_raw10: cover property ($rose(raw10_legacy_select));
    c_tick: cover property (internal_ref_tick);
endmodule
bind mrc_config mrc_config_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .power_enable_pin(power_enable_pin), .rx_lock(rx_lock),
    .operating_mode(operating_mode), .mode_settled(mode_settled),
    .raw10_legacy_select(raw10_legacy_select),
    .internal_ref_tick(internal_ref_tick),
    .use_internal_oscillator(use_internal_oscillator));

// *** tb/mrc_remote_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Remote deserializer and local clock source
// ==========================================================================
module mrc_remote_model (
    input  wire logic       aclk,
    input  wire logic       lock_cmd,
    input  wire logic [1:0] fmt,
    output logic            rx_lock,
    output logic            remote_raw10,
    output logic            remote_raw12,
    output logic            ext_clk,
    output logic            ext_present
);
    int delay;
    // Free-running local clock with an 80 ns period.
    initial begin
        ext_clk = 1'b0;
        #7;
        forever #40 ext_clk = ~ext_clk;
    end
    // Lock follows the command after a random delay of 1 to 8 cycles.
    initial begin
        rx_lock = 1'b0;
        forever begin
            @(posedge aclk);
            if (lock_cmd !== rx_lock) begin
                delay = 1 + $urandom % 8;
                repeat (delay) @(posedge aclk);
                rx_lock <= lock_cmd;
            end
        end
    end
    // Format lines are only valid while locked; otherwise show the inverse.
    assign remote_raw10 = rx_lock ? fmt[1] : ~fmt[1];
    assign remote_raw12 = rx_lock ? fmt[0] : ~fmt[0];
    // Bench bit fmt[0] high stands for a lost external clock.
    assign ext_present = ~fmt[0];
endmodule

// *** tb/test_mode_and_refclk_config.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Testbench for the mode and reference clock configuration block
// ==========================================================================
module test_mode_and_refclk_config;
    localparam SET = 2;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp, fmt = 2'h0, resp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        pin = 1'b0, lock_cmd = 1'b0;
    logic [2:0]  strap = 3'h0, om;
    logic        settled, r10, r12, tick, osc, use_int;
    logic        lock, raw10, raw12, ext_clk, present;
    logic [31:0] got;
    logic [2:0]  modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
    int          err_total = 0, compares = 0, ticks = 0, t0, i;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (tick === 1'b1) ticks <= ticks + 1;
    mrc_config #(.SETTLE_CYCLES(SET)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .power_enable_pin(pin), .mode_strap(strap),
        .external_input_clock(ext_clk), .external_clock_present(present),
        .rx_lock(lock), .remote_raw10(raw10), .remote_raw12(raw12),
        .operating_mode(om), .mode_settled(settled),
        .raw10_legacy_select(r10), .raw12_legacy_select(r12),
        .internal_ref_tick(tick), .oscillator_range_select(osc),
        .use_internal_oscillator(use_int));
    mrc_remote_model far_u (
        .aclk(aclk), .lock_cmd(lock_cmd), .fmt(fmt), .rx_lock(lock),
        .remote_raw10(raw10), .remote_raw12(raw12), .ext_clk(ext_clk),
        .ext_present(present));
    // ======================================================================
    // Bus tasks: ready is sampled at the falling edge.
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
        logic ga, gw, ta, tw, tb;
        ga = 0;
        gw = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(negedge aclk); ta = awready; tw = wready;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            ga |= ta; gw |= tw;
        end while (!(ga && gw));
        do begin
            @(negedge aclk); tb = bvalid; r = bresp;
            @(posedge aclk);
        end while (!tb);
        bready <= 0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
        logic ta, tv;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(negedge aclk); ta = arready;
            @(posedge aclk);
        end while (!ta);
        arvalid <= 0;
        do begin
            @(negedge aclk); tv = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
        end while (!tv);
        rready <= 0;
    endtask
    task automatic chk(input [31:0] e, input [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic [31:0] legacy_exp(input [1:0] f, input b);
        legacy_exp = {29'h0, f, b};
    endfunction
    // ======================================================================
    // Watchdog: the run needs well under 20000 cycles.
    initial begin
        #200000;
        err_total++;
        test_done;
    end
    // ======================================================================
    // Main sequence.
    initial begin
        void'($urandom(40));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of the mode, legacy and reference clock registers.
        rd(8'h0C, got, resp); chk(32'h00, got);
        rd(8'h10, got, resp); chk(32'h00, got);
        rd(8'h14, got, resp); chk(32'h03, got);
        // Latch a random legal strap on the power enable rise.
        @(posedge aclk) strap <= modes[$urandom % 4];
        @(posedge aclk) pin <= 1'b1;
        while (settled !== 1'b1) @(posedge aclk);
        rd(8'h0C, got, resp); chk({28'h0, 1'b1, strap}, got);
        chk(strap, om);
        // Mode writes with override clear are ignored.
        wr(8'h0C, {29'h0, ~strap}, resp);
        rd(8'h0C, got, resp); chk({28'h0, 1'b1, strap}, got);
        // Every legal mode through the override.
        for (i = 0; i < 4; i++) begin
            fmt <= $urandom % 4;
            wr(8'h0C, {27'h0, 1'b1, 1'b0, modes[i]}, resp);
            rd(8'h0C, got, resp); chk({27'h1, 1'b1, modes[i]}, got);
            repeat (4) @(posedge aclk);
            chk(modes[i], om);
            chk(modes[i] == 3'h3 || !present, use_int);
        end
        wr(8'h0C, 32'h0, resp);
        rd(8'h0C, got, resp); chk({28'h0, 1'b1, strap}, got);
        // Autoload on lock, then blocked autoload with other values.
        @(posedge aclk) fmt <= $urandom % 4;
        lock_cmd <= 1'b1;
        while (lock !== 1'b1) @(posedge aclk);
        repeat (6) @(posedge aclk);
        rd(8'h10, got, resp); chk(legacy_exp(fmt, 1'b0), got);
        chk(fmt, {r10, r12});
        lock_cmd <= 1'b0;
        wr(8'h10, 32'h01, resp);
        fmt <= ~fmt;
        while (lock !== 1'b0) @(posedge aclk);
        lock_cmd <= 1'b1;
        while (lock !== 1'b1) @(posedge aclk);
        repeat (6) @(posedge aclk);
        rd(8'h10, got, resp); chk(32'h01, got);
        chk(2'b00, {r10, r12});
        // Divider codes and oscillator range, ticks over 64 input periods.
        for (i = 0; i < 4; i++) begin
            fmt[0] = $urandom % 2;
            wr(8'h14, {25'h0, i[2:0], fmt[0], 3'h3}, resp);
            rd(8'h14, got, resp); chk({25'h0, i[2:0], fmt[0], 3'h3}, got);
            chk(fmt[0], osc);
            t0 = ticks;
            #5120;
            if ((ticks - t0) > (64 >> i) + 1 || (ticks - t0) < (64 >> i) - 1)
                chk(64 >> i, ticks - t0);
            else
                chk(0, 0);
        end
        // Unmapped place answers with a decode error both ways.
        wr(8'h40, 32'hFF, resp); chk(2'h3, resp);
        rd(8'h40, got, resp); chk(2'h3, resp);
        test_done;
    end
endmodule
